//--- design/pocl_consts.svh
// Purpose: offsets, strides, reset values of the output-level block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef POCL_CONSTS_SVH
`define POCL_CONSTS_SVH
`define POCL_GROUP_STRIDE 12'h080
`define POCL_OFF_LEVEL 7'h10
`define POCL_OFF_CLEAR 7'h14
`define POCL_OFF_SET 7'h18
`define POCL_OFF_TOGGLE 7'h1C
`define POCL_OFF_DIR 7'h00
`define POCL_OFF_PULL_RESISTOR_ENABLE 7'h04
`define POCL_LEVEL_RESET 32'h00000000
`define POCL_DIR_RESET 32'h00000000
`define POCL_PULL_RESISTOR_ENABLE_RESET 32'h00000000
`endif

//--- design/pocl_pkg.sv
// Purpose: shared types of the output-level block
// Assumes: 32 pins per group
// Notes: op codes of one register write
package pocl_pkg;
	typedef enum logic [2:0] {
		POCL_OP_NONE,
		POCL_OP_WRITE,
		POCL_OP_CLEAR,
		POCL_OP_SET,
		POCL_OP_TOGGLE
	} pocl_op_type;
	typedef struct packed {
		logic drive_en;
		logic drive_level;
		logic pull_en;
		logic pull_up;
	} pocl_pad_type;
endpackage

//--- design/pocl_pin_bit.sv
// Purpose: one stored output-level bit and its pad control
// Assumes: op decoded for the whole group
// Notes: one instance per pin
`include "pocl_consts.svh"
module pocl_pin_bit (
	input wire logic pclk,
	input wire logic presetn,
	input wire pocl_pkg::pocl_op_type op,
	input wire logic wbit,
	input wire logic dir,
	input wire logic pull_resistor_enable,
	output logic level,
	output pocl_pkg::pocl_pad_type pad
);
	logic level_r;
	logic level_nxt;
	always_comb begin
		case (op)
			pocl_pkg::POCL_OP_WRITE: level_nxt = wbit;
			pocl_pkg::POCL_OP_CLEAR: level_nxt = wbit ? 1'b0 : level_r;
			pocl_pkg::POCL_OP_SET: level_nxt = wbit ? 1'b1 : level_r;
			pocl_pkg::POCL_OP_TOGGLE: level_nxt = level_r ^ wbit;
			default: level_nxt = level_r;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_r <= 1'b0;
		end else begin
			level_r <= level_nxt;
		end
	end
	assign level = level_r;
	// pull only matters while the pin is an input
	assign pad.drive_en = dir;
	assign pad.drive_level = level_r;
	assign pad.pull_en = ~dir & pull_resistor_enable;
	assign pad.pull_up = ~dir & pull_resistor_enable & level_r;
endmodule // pocl_pin_bit

//--- design/pocl_apb_decode.sv
// Purpose: apb address decode into group and register
// Assumes: stride of 0x80 bytes, group 0 at base
// Notes: purely combinational
`include "pocl_consts.svh"
module pocl_apb_decode #(
	parameter int GROUPS = 2
) (
	input wire logic [11:0] paddr,
	output logic [GROUPS-1:0] grp_hit,
	output logic [6:0] reg_off,
	output logic addr_ok
);
	wire [4:0] grp_idx = paddr[11:7];
	assign reg_off = paddr[6:0];
	genvar g;
	generate
		for (g = 0; g < GROUPS; g++) begin : gen_hit
			assign grp_hit[g] = (grp_idx == 5'(g));
		end
	endgenerate
	assign addr_ok = (int'(grp_idx) < GROUPS) && (paddr[1:0] == 2'h0);
endmodule // pocl_apb_decode

//--- design/pocl_top.sv
// Purpose: clear/set/toggle output-level registers of a pin controller
// Assumes: apb slave, one clock pclk, async reset presetn
// Notes: direction and pull enable registers kept minimal for the pads
`include "pocl_consts.svh"
module pocl_top #(
	parameter int GROUPS = 2,
	parameter int PINS = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output pocl_pkg::pocl_pad_type [GROUPS*PINS-1:0] pad
);
	////////////////////////////////////////////////////////////////////////
	logic [GROUPS-1:0] grp_hit;
	logic [6:0] reg_off;
	logic addr_ok;
	pocl_apb_decode #(.GROUPS(GROUPS)) u_dec (
		.paddr(paddr),
		.grp_hit(grp_hit),
		.reg_off(reg_off),
		.addr_ok(addr_ok)
	);
	wire access = psel & penable;
	wire is_level = (reg_off == `POCL_OFF_LEVEL);
	wire is_clear = (reg_off == `POCL_OFF_CLEAR);
	wire is_set = (reg_off == `POCL_OFF_SET);
	wire is_toggle = (reg_off == `POCL_OFF_TOGGLE);
	wire is_dir = (reg_off == `POCL_OFF_DIR);
	wire is_pull_resistor_enable = (reg_off == `POCL_OFF_PULL_RESISTOR_ENABLE);
	wire reg_ok = addr_ok & (is_level | is_clear | is_set | is_toggle | is_dir | is_pull_resistor_enable);
	wire wr_fire = access & pwrite & reg_ok;
	// single-cycle access: no wait states
	assign pready = 1'b1;
	assign pslverr = access & ~reg_ok;
	pocl_pkg::pocl_op_type op_sel;
	assign op_sel = !wr_fire ? pocl_pkg::POCL_OP_NONE :
		is_level ? pocl_pkg::POCL_OP_WRITE :
		is_clear ? pocl_pkg::POCL_OP_CLEAR :
		is_set ? pocl_pkg::POCL_OP_SET :
		is_toggle ? pocl_pkg::POCL_OP_TOGGLE : pocl_pkg::POCL_OP_NONE;
	////////////////////////////////////////////////////////////////////////
	logic [GROUPS-1:0][31:0] level_w;
	logic [GROUPS-1:0][31:0] dir_r;
	logic [GROUPS-1:0][31:0] pull_resistor_enable_r;
	logic [31:0] prdata_nxt;
	genvar g, p;
	generate
		for (g = 0; g < GROUPS; g++) begin : gen_grp
			wire pocl_pkg::pocl_op_type gop = grp_hit[g] ? op_sel : pocl_pkg::POCL_OP_NONE;
			// one register per group: a shared array would have several writers
			logic [31:0] gdir_r;
			logic [31:0] gpullen_r;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					gdir_r <= `POCL_DIR_RESET;
					gpullen_r <= `POCL_PULL_RESISTOR_ENABLE_RESET;
				end else if (wr_fire && grp_hit[g]) begin
					if (is_dir) gdir_r <= pwdata;
					if (is_pull_resistor_enable) gpullen_r <= pwdata;
				end
			end
			assign dir_r[g] = gdir_r;
			assign pull_resistor_enable_r[g] = gpullen_r;
			for (p = 0; p < 32; p++) begin : gen_pin
				if (p < PINS) begin : gen_on
					// every bit sees the same write: many pins at once
					pocl_pin_bit u_bit (
						.pclk(pclk),
						.presetn(presetn),
						.op(gop),
						.wbit(pwdata[p]),
						.dir(dir_r[g][p]),
						.pull_resistor_enable(pull_resistor_enable_r[g][p]),
						.level(level_w[g][p]),
						.pad(pad[g*PINS+p])
					);
				end else begin : gen_off
					assign level_w[g][p] = 1'b0;
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////
	// read mux: four registers show one shared value
	always_comb begin
		prdata_nxt = 32'h00000000;
		for (int i = 0; i < GROUPS; i++) begin
			if (grp_hit[i]) begin
				if (is_level | is_clear | is_set | is_toggle) prdata_nxt = level_w[i];
				else if (is_dir) prdata_nxt = dir_r[i];
				else if (is_pull_resistor_enable) prdata_nxt = pull_resistor_enable_r[i];
			end
		end
	end
	assign prdata = (access & ~pwrite & reg_ok) ? prdata_nxt : 32'h00000000;
	////////////////////////////////////////////////////////////////////////
	// checks
	AST_SET_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		wr_fire && grp_hit[0] && is_set && pwdata[0] |=> level_w[0][0])
		else $error("set did not raise level");
	AST_CLR_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		wr_fire && grp_hit[0] && is_clear && pwdata[0] |=> !level_w[0][0])
		else $error("clear did not drop level");
	AST_TGL_INV: assert property (@(posedge pclk) disable iff (!presetn)
		wr_fire && grp_hit[0] && is_toggle && pwdata[0] |=> level_w[0][0] != $past(level_w[0][0]))
		else $error("toggle did not invert");
	AST_ZERO_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		wr_fire && grp_hit[0] && !is_level && !pwdata[0] |=> $stable(level_w[0][0]))
		else $error("zero bit changed level");
	AST_IDLE_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_fire |=> $stable(level_w))
		else $error("level moved without write");
	AST_READ_SHARED: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pwrite && grp_hit[0] && is_set |-> prdata == level_w[0])
		else $error("set read not level");
	AST_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
		dir_r[0][0] |-> pad[0].drive_en && pad[0].drive_level == level_w[0][0])
		else $error("output drive wrong");
	AST_PULL: assert property (@(posedge pclk) disable iff (!presetn)
		!dir_r[0][0] && pull_resistor_enable_r[0][0] |-> pad[0].pull_en && pad[0].pull_up == level_w[0][0])
		else $error("pull direction wrong");
	AST_MULTI: assert property (@(posedge pclk) disable iff (!presetn)
		wr_fire && grp_hit[0] && is_set && pwdata == 32'hFFFFFFFF |=> &level_w[0][PINS-1:0])
		else $error("multi-pin set failed");
endmodule // pocl_top

//--- bench/pocl_top_tb.sv
// Purpose: self-checking bench of the output-level block
// Assumes: bench is the apb master, arrays mirror the registers
// Notes: random ops from xorshift seeded 70, corners among them
module pocl_top_tb;
timeunit 1ns;
timeprecision 1ns;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, seed, rd, m_lvl[2], m_dir[2], m_pen[2];
logic [6:0] offs[6] = '{7'h00, 7'h04, 7'h10, 7'h14, 7'h18, 7'h1C};
pocl_pkg::pocl_pad_type [63:0] pad;
int n_errors, n_compared, cyc;
pocl_top #(.GROUPS(2), .PINS(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pad(pad));
initial begin
	pclk = 1'b0;
	forever #50 pclk = ~pclk;
end
////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] xs();
	seed ^= seed << 13;
	seed ^= seed >> 17;
	seed ^= seed << 5;
	return seed;
endfunction
function automatic logic ok(input logic [11:0] a);
	return a[1:0] == 2'h0 && a[11:8] == 4'h0 && a[6:0] inside {7'h00, 7'h04, 7'h10, 7'h14, 7'h18, 7'h1C};
endfunction
function automatic logic [31:0] exp_rd(input logic [11:0] a);
	if (!ok(a)) return 32'h00000000;
	if (a[6:0] == 7'h00) return m_dir[a[7]];
	if (a[6:0] == 7'h04) return m_pen[a[7]];
	return m_lvl[a[7]];
endfunction
task chk(input logic [31:0] seen, input logic [31:0] exp);
	n_compared++;
	if (seen !== exp) begin
		n_errors++;
		$display("Error at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
////////////////////////////////////////////////////////////////////////////////
// caller sits just after a rising edge; one idle cycle follows each transfer
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	int k;
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	k = 0;
	do begin
		@(posedge pclk);
		k++;
	end while (pready !== 1'b1 && k < 50);
	rd = prdata;
	er = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
	@(posedge pclk);
endtask
task model(input logic [11:0] a, input logic [31:0] d);
	if (ok(a)) case (a[6:0])
		7'h00: m_dir[a[7]] = d;
		7'h04: m_pen[a[7]] = d;
		7'h10: m_lvl[a[7]] = d;
		7'h14: m_lvl[a[7]] &= ~d;
		7'h18: m_lvl[a[7]] |= d;
		7'h1C: m_lvl[a[7]] ^= d;
		default: ;
	endcase
endtask
task pads();
	logic l, p;
	for (int i = 0; i < 64; i++) begin
		l = m_lvl[i / 32][i % 32];
		p = m_pen[i / 32][i % 32];
		if (m_dir[i / 32][i % 32])
			chk({30'h0, pad[i].drive_en, pad[i].drive_level}, {30'h0, 1'b1, l});
		else
			chk({29'h0, pad[i].drive_en, pad[i].pull_en, pad[i].pull_up}, {29'h0, 1'b0, p, p & l});
	end
endtask
// async reset held 8 cycles; first setup one edge after release
task reset_all();
	presetn <= 1'b0;
	repeat (8) @(posedge pclk);
	presetn <= 1'b1;
	@(posedge pclk);
	for (int g = 0; g < 2; g++) begin
		m_lvl[g] = 32'h00000000;
		m_dir[g] = 32'h00000000;
		m_pen[g] = 32'h00000000;
	end
endtask
task give_verdict();
	$display("compared %0d, mismatches %0d", n_compared, n_errors);
	if (n_errors == 0 && n_compared > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
// run is some 2500 cycles; a hang far beyond that is cut off
always @(posedge pclk) begin
	cyc++;
	if (cyc == 20000) begin
		n_errors++;
		give_verdict();
	end
end
initial begin
	logic [31:0] r, d;
	logic [11:0] a;
	seed = 32'h00000046;
	{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
	{n_errors, n_compared, cyc} = '0;
	for (int pass = 0; pass < 2; pass++) begin
		reset_all();
		pads();
		for (int k = 0; k < 12; k++) begin
			apb(1'b0, {4'h0, k[0], offs[k / 2]}, 32'h00000000);
			chk(rd, 32'h00000000);
			chk({31'h0, er}, 32'h00000000);
		end
		$display("test reset values done");
		for (int n = 0; n < 200; n++) begin
			r = xs();
			a = (r[31:29] == 3'h0) ? r[11:0] : {4'h0, r[8], offs[r[18:16] % 6]};
			d = xs();
			if (n % 16 == 0) d = 32'hFFFFFFFF;
			if (n % 16 == 8) d = 32'h00000000;
			apb(1'b1, a, d);
			chk({31'h0, er}, {31'h0, !ok(a)});
			model(a, d);
			pads();
			r = xs();
			a = {4'h0, a[7], offs[2 + r[1:0]]};
			apb(1'b0, a, 32'h00000000);
			chk(rd, exp_rd(a));
		end
		$display("test random ops pass %0d done", pass);
	end
	give_verdict();
end
endmodule // pocl_top_tb
